// ---- hdl/bpu_pkg.sv ----
package bpu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W = 32;
  localparam int CTR_W = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Default geometry, given as log2 of a count (sets, ways, table entries, pattern columns) except HIST_LEN_DEF, a history length in bits
  localparam int SETS_LOG2_DEF = 6;
  localparam int WAYS_LOG2_DEF = 2;
  localparam int CTR_TABLE_LOG2_DEF = 10;
  localparam int HIST_TABLE_LOG2_DEF = 4;
  localparam int HIST_LEN_DEF = 8;
  localparam int PAT_COL_LOG2_DEF = 2;
  localparam int SEL_TABLE_LOG2_DEF = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Saturating counter values
  localparam logic [CTR_W-1:0] CTR_MIN = 2'h0;
  localparam logic [CTR_W-1:0] CTR_MAX = 2'h3;
  localparam logic [CTR_W-1:0] CTR_RESET = 2'h0;
  localparam int CTR_TAKEN_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Direction predictor modes
  typedef enum logic [2:0] {
    MODE_ORACLE = 3'h0,
    MODE_STATIC_TAKEN = 3'h1,
    MODE_STATIC_FALLTHROUGH = 3'h3,
    MODE_COUNTER_TABLE = 3'h2,
    MODE_HISTORY_INDEXED = 3'h6,
    MODE_HYBRID = 3'h7
  } bpu_mode_t;

  typedef enum logic [1:0] {
    BR_COND = 2'h0,
    BR_JUMP = 2'h1,
    BR_CALL = 2'h2,
    BR_RET = 2'h3
  } bpu_kind_t;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic taken;
    logic [ADDR_W-1:0] target;
    bpu_kind_t kind;
  } bpu_commit_t;

  typedef struct packed {
    logic hit;
    logic taken;
    logic [ADDR_W-1:0] target;
    bpu_kind_t kind;
  } bpu_pred_t;

endpackage

// ---- hdl/bpu_sat_ctr.sv ----
`timescale 1ns/100ps
module bpu_sat_ctr
(
  input wire logic [bpu_pkg::CTR_W-1:0] cur,
  input wire logic up,
  output logic [bpu_pkg::CTR_W-1:0] nxt
);

  always_comb
  begin
    nxt = cur;
    if (up && cur != bpu_pkg::CTR_MAX)
    begin
      nxt = cur + 2'h1;
    end
    else if (!up && cur != bpu_pkg::CTR_MIN)
    begin
      nxt = cur - 2'h1;
    end
  end

endmodule

// ---- hdl/bpu_top.sv ----
`timescale 1ns/100ps
module bpu_top
#(
  parameter int SETS_LOG2 = bpu_pkg::SETS_LOG2_DEF,
  parameter int WAYS_LOG2 = bpu_pkg::WAYS_LOG2_DEF,
  parameter int CTR_TABLE_LOG2 = bpu_pkg::CTR_TABLE_LOG2_DEF,
  parameter int HIST_TABLE_LOG2 = bpu_pkg::HIST_TABLE_LOG2_DEF,
  parameter int HIST_LEN = bpu_pkg::HIST_LEN_DEF,
  parameter int PAT_COL_LOG2 = bpu_pkg::PAT_COL_LOG2_DEF,
  parameter int SEL_TABLE_LOG2 = bpu_pkg::SEL_TABLE_LOG2_DEF
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire bpu_pkg::bpu_mode_t predMode,
  input wire logic lookupValid,
  input wire logic [bpu_pkg::ADDR_W-1:0] lookupAddr,
  input wire bpu_pkg::bpu_pred_t oracleInfo,
  input wire logic commitValid,
  input wire bpu_pkg::bpu_commit_t commitInfo,
  output logic predValid,
  output bpu_pkg::bpu_pred_t pred
);

  ////////////////////////////////////////////////////////////////////////////
  // Geometry; log2 parameters make every count a power of two
  localparam int SETS = 1 << SETS_LOG2;
  localparam int WAYS = 1 << WAYS_LOG2;
  localparam int WB = (WAYS_LOG2 == 0) ? 1 : WAYS_LOG2;
  localparam int CTR_N = 1 << CTR_TABLE_LOG2;
  localparam int HIST_N = 1 << HIST_TABLE_LOG2;
  localparam int PAT_IW = HIST_LEN + PAT_COL_LOG2;
  localparam int PAT_N = 1 << PAT_IW;
  localparam int SEL_N = 1 << SEL_TABLE_LOG2;
  localparam int AW = bpu_pkg::ADDR_W;
  localparam int TB = bpu_pkg::CTR_TAKEN_BIT;

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic btbValid_q [SETS][WAYS];
  logic [AW-1:0] btbTag_q [SETS][WAYS];
  logic [AW-1:0] btbTarget_q [SETS][WAYS];
  bpu_pkg::bpu_kind_t btbKind_q [SETS][WAYS];
  logic [WB-1:0] victim_q [SETS];
  logic [1:0] ctrTab_q [CTR_N];
  logic [HIST_LEN-1:0] hist_q [HIST_N];
  logic [1:0] pat_q [PAT_N];
  logic [1:0] sel_q [SEL_N];
  logic predValid_q;
  logic predValid_d;
  bpu_pkg::bpu_pred_t pred_q;
  bpu_pkg::bpu_pred_t pred_d;

  ////////////////////////////////////////////////////////////////////////////
  // Index extraction
  logic [SETS_LOG2-1:0] lkSet;
  logic [SETS_LOG2-1:0] cmSet;
  logic [CTR_TABLE_LOG2-1:0] lkCtrIdx;
  logic [CTR_TABLE_LOG2-1:0] cmCtrIdx;
  logic [HIST_TABLE_LOG2-1:0] lkHistIdx;
  logic [HIST_TABLE_LOG2-1:0] cmHistIdx;
  logic [PAT_IW-1:0] lkPatIdx;
  logic [PAT_IW-1:0] cmPatIdx;
  logic [SEL_TABLE_LOG2-1:0] lkSelIdx;
  logic [SEL_TABLE_LOG2-1:0] cmSelIdx;

  assign lkSet = lookupAddr[SETS_LOG2-1:0];
  assign cmSet = commitInfo.addr[SETS_LOG2-1:0];
  assign lkCtrIdx = lookupAddr[CTR_TABLE_LOG2-1:0];
  assign cmCtrIdx = commitInfo.addr[CTR_TABLE_LOG2-1:0];
  assign lkHistIdx = lookupAddr[HIST_TABLE_LOG2-1:0];
  assign cmHistIdx = commitInfo.addr[HIST_TABLE_LOG2-1:0];
  // Row from history, column from address bits
  assign lkPatIdx = {hist_q[lkHistIdx], lookupAddr[PAT_COL_LOG2-1:0]};
  assign cmPatIdx = {hist_q[cmHistIdx], commitInfo.addr[PAT_COL_LOG2-1:0]};
  assign lkSelIdx = lookupAddr[SEL_TABLE_LOG2-1:0];
  assign cmSelIdx = commitInfo.addr[SEL_TABLE_LOG2-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Per-way tag compare for both ports; tag is the full address
  logic [WAYS-1:0] lkWayHit;
  logic [WAYS-1:0] cmWayHit;
  logic [WAYS-1:0] cmWayFree;

  for (genvar w = 0; w < WAYS; w++)
  begin : gWay
    assign lkWayHit[w] = btbValid_q[lkSet][w] && (btbTag_q[lkSet][w] == lookupAddr);
    assign cmWayHit[w] = btbValid_q[cmSet][w] && (btbTag_q[cmSet][w] == commitInfo.addr);
    assign cmWayFree[w] = !btbValid_q[cmSet][w];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lookup and prediction
  logic lkHit;
  logic [AW-1:0] lkTarget;
  bpu_pkg::bpu_kind_t lkKind;
  logic lkDir;
  logic lkCtrDir;
  logic lkPatDir;

  always_comb
  begin
    lkHit = 1'b0;
    lkTarget = '0;
    lkKind = bpu_pkg::BR_COND;
    for (int w = WAYS - 1; w >= 0; w--)
    begin
      if (lkWayHit[w])
      begin
        lkHit = 1'b1;
        lkTarget = btbTarget_q[lkSet][w];
        lkKind = btbKind_q[lkSet][w];
      end
    end
  end

  // Counter upper bit set means 2 or 3, so 0 and 1 read as not taken
  assign lkCtrDir = ctrTab_q[lkCtrIdx][TB];
  assign lkPatDir = pat_q[lkPatIdx][TB];

  always_comb
  begin
    lkDir = 1'b0;
    unique case (predMode)
      bpu_pkg::MODE_ORACLE:
      begin
        lkDir = oracleInfo.taken;
      end
      bpu_pkg::MODE_STATIC_TAKEN:
      begin
        lkDir = 1'b1;
      end
      bpu_pkg::MODE_STATIC_FALLTHROUGH:
      begin
        lkDir = (lkKind != bpu_pkg::BR_COND);
      end
      bpu_pkg::MODE_COUNTER_TABLE:
      begin
        lkDir = (lkKind != bpu_pkg::BR_COND) || lkCtrDir;
      end
      bpu_pkg::MODE_HISTORY_INDEXED:
      begin
        lkDir = (lkKind != bpu_pkg::BR_COND) || lkPatDir;
      end
      bpu_pkg::MODE_HYBRID:
      begin
        // Both results are held; selector 0 or 1 obeys the counter table
        lkDir = (lkKind != bpu_pkg::BR_COND) ||
                (sel_q[lkSelIdx][TB] ? lkPatDir : lkCtrDir);
      end
      default:
      begin
        lkDir = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    predValid_d = lookupValid;
    pred_d = pred_q;
    if (lookupValid)
    begin
      if (predMode == bpu_pkg::MODE_ORACLE)
      begin
        pred_d.hit = 1'b1;
        pred_d.taken = oracleInfo.taken;
        pred_d.target = oracleInfo.target;
        pred_d.kind = oracleInfo.kind;
      end
      else
      begin
        // A miss never consults the direction logic: fetch goes sequential
        pred_d.hit = lkHit;
        pred_d.taken = lkHit && lkDir;
        pred_d.target = lkTarget;
        pred_d.kind = lkKind;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      predValid_q <= 1'b0;
      pred_q <= '0;
    end
    else
    begin
      predValid_q <= predValid_d;
      pred_q <= pred_d;
    end
  end

  assign predValid = predValid_q;
  assign pred = pred_q;

  ////////////////////////////////////////////////////////////////////////////
  // Commit-side update; each valid cycle is one resolved branch
  logic [1:0] cmCtrNext;
  logic [1:0] cmPatNext;
  logic [1:0] cmSelNext;
  logic cmCtrPred;
  logic cmPatPred;
  logic cmSelUp;
  logic selWrEn;
  logic btbWrEn;
  logic [WB-1:0] btbWrWay;
  logic victimAdv;
  logic [HIST_LEN-1:0] histNext;

  assign cmCtrPred = ctrTab_q[cmCtrIdx][TB];
  assign cmPatPred = pat_q[cmPatIdx][TB];
  // Move toward the two-level side only when it was the one that was right
  assign cmSelUp = (cmPatPred == commitInfo.taken);
  assign selWrEn = commitValid && (cmCtrPred != cmPatPred);
  assign histNext = {hist_q[cmHistIdx][HIST_LEN-2:0], commitInfo.taken};

  bpu_sat_ctr uCtrUpd
  (
    .cur(ctrTab_q[cmCtrIdx]),
    .up(commitInfo.taken),
    .nxt(cmCtrNext)
  );

  bpu_sat_ctr uPatUpd
  (
    .cur(pat_q[cmPatIdx]),
    .up(commitInfo.taken),
    .nxt(cmPatNext)
  );

  bpu_sat_ctr uSelUpd
  (
    .cur(sel_q[cmSelIdx]),
    .up(cmSelUp),
    .nxt(cmSelNext)
  );

  // Hit way is refreshed; otherwise the lowest free way, else round robin
  always_comb
  begin
    btbWrEn = commitValid;
    btbWrWay = victim_q[cmSet];
    victimAdv = commitValid;
    for (int w = WAYS - 1; w >= 0; w--)
    begin
      if (cmWayFree[w])
      begin
        btbWrWay = WB'(w);
        victimAdv = 1'b0;
      end
    end
    for (int w = WAYS - 1; w >= 0; w--)
    begin
      if (cmWayHit[w])
      begin
        btbWrWay = WB'(w);
        victimAdv = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int s = 0; s < SETS; s++)
      begin
        victim_q[s] <= '0;
        for (int w = 0; w < WAYS; w++)
        begin
          btbValid_q[s][w] <= 1'b0;
          btbTag_q[s][w] <= '0;
          btbTarget_q[s][w] <= '0;
          btbKind_q[s][w] <= bpu_pkg::BR_COND;
        end
      end
      for (int i = 0; i < CTR_N; i++)
        ctrTab_q[i] <= bpu_pkg::CTR_RESET;
      for (int i = 0; i < HIST_N; i++)
        hist_q[i] <= '0;
      for (int i = 0; i < PAT_N; i++)
        pat_q[i] <= bpu_pkg::CTR_RESET;
      for (int i = 0; i < SEL_N; i++)
        sel_q[i] <= bpu_pkg::CTR_RESET;
    end
    else
    begin
      if (btbWrEn)
      begin
        btbValid_q[cmSet][btbWrWay] <= 1'b1;
        btbTag_q[cmSet][btbWrWay] <= commitInfo.addr;
        btbTarget_q[cmSet][btbWrWay] <= commitInfo.target;
        btbKind_q[cmSet][btbWrWay] <= commitInfo.kind;
      end
      if (victimAdv)
      begin
        victim_q[cmSet] <= victim_q[cmSet] + 1'b1;
      end
      // Direction state only learns from conditional branches
      if (commitValid && commitInfo.kind == bpu_pkg::BR_COND)
      begin
        ctrTab_q[cmCtrIdx] <= cmCtrNext;
        pat_q[cmPatIdx] <= cmPatNext;
        hist_q[cmHistIdx] <= histNext;
        if (selWrEn)
        begin
          sel_q[cmSelIdx] <= cmSelNext;
        end
      end
    end
  end

endmodule

// ---- bench/bpu_top_assertions.sv ----
`timescale 1ns/100ps
module bpu_top_assertions
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire bpu_pkg::bpu_mode_t predMode,
  input wire logic lookupValid,
  input wire logic [bpu_pkg::ADDR_W-1:0] lookupAddr,
  input wire bpu_pkg::bpu_pred_t oracleInfo,
  input wire logic commitValid,
  input wire bpu_pkg::bpu_commit_t commitInfo,
  input wire logic predValid,
  input wire bpu_pkg::bpu_pred_t pred
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_answer;
    lookupValid |=> predValid;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_idle;
    !lookupValid |=> !predValid && $stable(pred);
  endproperty
  a_idle: assert property (p_idle) else $error("output moved");
  property p_oracle;
    lookupValid && predMode == bpu_pkg::MODE_ORACLE
      |=> pred.hit && pred[34:0] == $past(oracleInfo[34:0]);
  endproperty
  a_oracle: assert property (p_oracle) else $error("oracle wrong");
  property p_miss;
    predValid && !pred.hit |-> !pred.taken;
  endproperty
  a_miss: assert property (p_miss) else $error("miss taken");
  property p_taken;
    lookupValid && predMode == bpu_pkg::MODE_STATIC_TAKEN |=> pred.taken == pred.hit;
  endproperty
  a_taken: assert property (p_taken) else $error("static taken wrong");
  property p_fall;
    lookupValid && predMode == bpu_pkg::MODE_STATIC_FALLTHROUGH
      |=> pred.taken == (pred.hit && pred.kind != bpu_pkg::BR_COND);
  endproperty
  a_fall: assert property (p_fall) else $error("fallthrough wrong");
  property p_uncond;
    lookupValid && predMode[1]
      |=> !(pred.hit && pred.kind != bpu_pkg::BR_COND) || pred.taken;
  endproperty
  a_uncond: assert property (p_uncond) else $error("jump not taken");
  // One quiet cycle between, so no later commit can overwrite the entry
  sequence s_learn;
    commitValid ##1 !commitValid ##1 lookupValid
      && lookupAddr == $past(commitInfo.addr, 2) && predMode != bpu_pkg::MODE_ORACLE;
  endsequence
  property p_learn;
    s_learn |=> pred.hit && pred.target == $past(commitInfo.target, 3)
      && pred.kind == $past(commitInfo.kind, 3);
  endproperty
  a_learn: assert property (p_learn) else $error("entry not found");
  c_learn: cover property (s_learn);
  c_oracle: cover property (lookupValid && predMode == bpu_pkg::MODE_ORACLE);
  c_hybrid: cover property (lookupValid && predMode == bpu_pkg::MODE_HYBRID);
endmodule
bind bpu_top bpu_top_assertions bpu_top_assertions_i (.ref_clk, .arst_n, .predMode,
  .lookupValid, .lookupAddr, .oracleInfo, .commitValid, .commitInfo, .predValid, .pred);

// ---- bench/bpu_pipe_model.sv ----
`timescale 1ns/100ps
module bpu_pipe_model
(
  input wire logic ref_clk,
  output bpu_pkg::bpu_mode_t predMode,
  output logic lookupValid,
  output logic [bpu_pkg::ADDR_W-1:0] lookupAddr,
  output logic commitValid,
  output bpu_pkg::bpu_commit_t commitInfo
);
  initial
  begin
    predMode = bpu_pkg::MODE_ORACLE;
    lookupValid = 1'b0;
    lookupAddr = '0;
    commitValid = 1'b0;
    commitInfo = '0;
  end
  // Address and commit lines turn to junk once the strobe drops (predMode holds), so stale values cannot pass
  task automatic lookup(input bpu_pkg::bpu_mode_t m, input logic [31:0] a);
    @(posedge ref_clk);
    predMode <= m;
    lookupValid <= 1'b1;
    lookupAddr <= a;
    @(posedge ref_clk);
    lookupValid <= 1'b0;
    lookupAddr <= ~a;
  endtask
  task automatic commit(input logic [31:0] a, input logic t, input logic [31:0] g,
    input logic [1:0] k);
    @(posedge ref_clk);
    commitValid <= 1'b1;
    commitInfo <= {a, t, g, k};
    @(posedge ref_clk);
    commitValid <= 1'b0;
    commitInfo <= ~commitInfo;
  endtask
endmodule

// ---- bench/bpu_top_test.sv ----
`timescale 1ns/100ps
module bpu_top_test;
  logic ref_clk;
  logic arst_n;
  bpu_pkg::bpu_mode_t predMode;
  logic lookupValid;
  logic [31:0] lookupAddr;
  bpu_pkg::bpu_pred_t oracleInfo;
  logic commitValid;
  bpu_pkg::bpu_commit_t commitInfo;
  logic predValid;
  bpu_pkg::bpu_pred_t pred;
  int errCount = 0;
  int checks = 0;
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Small buffer and history so eviction and saturation show up in few commits
  bpu_top #(.SETS_LOG2(2), .WAYS_LOG2(1), .HIST_TABLE_LOG2(2), .HIST_LEN(3),
    .PAT_COL_LOG2(1)) bpu_top_i (.ref_clk, .arst_n,
    .predMode, .lookupValid, .lookupAddr, .oracleInfo, .commitValid, .commitInfo,
    .predValid, .pred);
  bpu_pipe_model bpu_pipe_model_i (.ref_clk, .predMode, .lookupValid, .lookupAddr,
    .commitValid, .commitInfo);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [36:0] s, input logic [36:0] e);
    checks++;
    if (s !== e)
    begin
      errCount++;
      $display("Error %0t: got %h exp %h", $time, s, e);
    end
  endtask
  task automatic wrapUp;
    if (errCount == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rst;
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk({predValid, pred}, '0);
    arst_n <= 1'b1;
  endtask
  task automatic look(input bpu_pkg::bpu_mode_t m, input logic [31:0] a);
    bpu_pipe_model_i.lookup(m, a);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic tOracle;
    rst;
    @(posedge ref_clk);
    oracleInfo <= {1'b1, 1'b1, 32'habc, bpu_pkg::BR_RET};
    look(bpu_pkg::MODE_ORACLE, 32'h500);
    chk({predValid, pred}, {1'b1, oracleInfo});
  endtask
  task automatic tStatic;
    rst;
    look(bpu_pkg::MODE_STATIC_TAKEN, 32'h100);
    chk({predValid, pred.hit, pred.taken}, 3'h4);
    for (int k = 0; k < 4; k++)
      bpu_pipe_model_i.commit(32'h100 + k, 1'b0, 32'h200 + k, k[1:0]);
    for (int k = 0; k < 4; k++)
    begin
      look(bpu_pkg::MODE_STATIC_TAKEN, 32'h100 + k);
      chk({predValid, pred}, {3'h7, 32'h200 + k, k[1:0]});
      look(bpu_pkg::MODE_STATIC_FALLTHROUGH, 32'h100 + k);
      chk({predValid, pred}, {2'h3, k != 0, 32'h200 + k, k[1:0]});
    end
    look(bpu_pkg::MODE_STATIC_TAKEN, 32'h1100);
    chk({predValid, pred.hit, pred.taken}, 3'h4);
  endtask
  task automatic tCtr;
    logic [5:0] o;
    logic [5:0] e;
    o = 6'h0f;
    e = 6'h1e;
    rst;
    for (int i = 0; i < 6; i++)
    begin
      bpu_pipe_model_i.commit(32'h23, o[i], 32'h777, bpu_pkg::BR_COND);
      look(bpu_pkg::MODE_COUNTER_TABLE, 32'h23);
      chk({predValid, pred}, {2'h3, e[i], 32'h777, 2'h0});
    end
  endtask
  // Four branches in one two-way set: the third evicts the first, the fourth the second
  task automatic tEvict;
    rst;
    for (int k = 0; k < 4; k++)
      bpu_pipe_model_i.commit(32'h100 + 4 * k, 1'b1, 32'h300 + k, bpu_pkg::BR_JUMP);
    for (int k = 0; k < 4; k++)
    begin
      look(bpu_pkg::MODE_STATIC_TAKEN, 32'h100 + 4 * k);
      if (k < 2)
        chk({predValid, pred.hit, pred.taken}, 3'h4);
      else
        chk({predValid, pred}, {3'h7, 32'h300 + k, 2'h1});
    end
  endtask
  // Alternating branch: counter stays low, history learns it, selector follows late
  task automatic tDyn;
    rst;
    for (int i = 1; i <= 10; i++)
    begin
      bpu_pipe_model_i.commit(32'h40, i[0], 32'h888, bpu_pkg::BR_COND);
      if (i >= 6 && !i[0])
      begin
        look(bpu_pkg::MODE_COUNTER_TABLE, 32'h40);
        chk({predValid, pred}, {3'h6, 32'h888, 2'h0});
        look(bpu_pkg::MODE_HISTORY_INDEXED, 32'h40);
        chk({predValid, pred}, {3'h7, 32'h888, 2'h0});
        look(bpu_pkg::MODE_HYBRID, 32'h40);
        chk({predValid, pred}, {2'h3, i == 10, 32'h888, 2'h0});
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    arst_n = 1'b0;
    oracleInfo = '0;
    tOracle;
    tStatic;
    tEvict;
    tCtr;
    tDyn;
    wrapUp;
  end
  initial
  begin
    #100000;
    errCount++;
    wrapUp;
  end
endmodule
